// *** pkg/dclp_pkg.sv ***
// Purpose: shared constants, types and helpers for the dual coefficient load port
// Assumes: one device clock; host logic drives both load ports on that clock
// Notes:   address word = class in the top three bits, inner address below

package dclp_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int WORD_W     = 12;                   // one load word
    localparam int CLASS_W    = 3;                    // target class field
    localparam int CLASS_LSB  = 9;                    // class sits in bits 11..9
    localparam int INNER_W    = 9;                    // address inside a class
    localparam int COEF_ROW_W = 8;                    // 256 rows per bank
    localparam int COEF_WORDS = 8;                    // one word per bank
    localparam int COEF_SET_W = COEF_WORDS * WORD_W;  // a whole coefficient set
    localparam int REG_W      = 32;                   // widest control register
    localparam int BYTE_W     = 8;                    // round register byte
    localparam int CNT_W      = 3;                    // data word index
    localparam int ENTRY_W    = CLASS_W + INNER_W + REG_W;

    // ------------------------------------------------------------------
    // target classes
    // ------------------------------------------------------------------
    localparam logic [CLASS_W-1:0] CLS_COEF    = 3'h0;
    localparam logic [CLASS_W-1:0] CLS_CONFIG  = 3'h1;
    localparam logic [CLASS_W-1:0] CLS_HSELECT = 3'h2;
    localparam logic [CLASS_W-1:0] CLS_VSELECT = 3'h3;
    localparam logic [CLASS_W-1:0] CLS_HROUND  = 3'h4;
    localparam logic [CLASS_W-1:0] CLS_VROUND  = 3'h5;
    localparam logic [CLASS_W-1:0] CLS_HLIMIT  = 3'h6;
    localparam logic [CLASS_W-1:0] CLS_VLIMIT  = 3'h7;

    // ------------------------------------------------------------------
    // index of the last data word per class (words after the address - 1)
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] LAST_COEF   = 3'h7;
    localparam logic [CNT_W-1:0] LAST_ROUND  = 3'h3;
    localparam logic [CNT_W-1:0] LAST_LIMIT  = 3'h1;
    localparam logic [CNT_W-1:0] LAST_SINGLE = 3'h0;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,  // strobe high, waiting for a falling strobe
        ST_ADDR = 3'b010,  // group done, next low word is an address
        ST_DATA = 3'b100   // collecting data words
    } dclp_state_type;

    // last data word index for a class
    function automatic logic [CNT_W-1:0] lastIndex(input logic [CLASS_W-1:0] cls);
        case (cls)
            CLS_COEF:               lastIndex = LAST_COEF;
            CLS_HROUND, CLS_VROUND: lastIndex = LAST_ROUND;
            CLS_HLIMIT, CLS_VLIMIT: lastIndex = LAST_LIMIT;
            default:                lastIndex = LAST_SINGLE;
        endcase
    endfunction

    // true for a round register class
    function automatic logic isRound(input logic [CLASS_W-1:0] cls);
        isRound = (cls == CLS_HROUND) || (cls == CLS_VROUND);
    endfunction

    // true for a limit register class
    function automatic logic isLimit(input logic [CLASS_W-1:0] cls);
        isLimit = (cls == CLS_HLIMIT) || (cls == CLS_VLIMIT);
    endfunction

endpackage

// *** src/dclp_port.sv ***
// Purpose: one load port sequencer: address word, then a fixed group of data words
// Assumes: strobe and word come from host logic on the same clock, no synchroniser
// Notes:   commits are one-cycle pulses; the group is held until its last word

`timescale 1ns/1ps

module dclp_port (
    input  wire logic                          clock,
    input  wire logic                          rst_n,
    input  wire logic                          strobe_n,  // load strobe, active low
    input  wire logic [dclp_pkg::WORD_W-1:0]   loadWord,  // address or data word
    output logic                               coefWrite, // coefficient set commit pulse
    output logic [dclp_pkg::COEF_ROW_W-1:0]    coefRow,   // row in every bank
    output logic [dclp_pkg::COEF_SET_W-1:0]    coefSet,   // bank 0 in the low word
    output logic                               regWrite,  // register commit pulse
    output logic [dclp_pkg::CLASS_W-1:0]       regClass,  // register class
    output logic [dclp_pkg::INNER_W-1:0]       regAddr,   // register index
    output logic [dclp_pkg::REG_W-1:0]         regData    // assembled register value
);
    import dclp_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    dclp_state_type       state, next_state;          // sequencer
    logic                 strobeSeen, next_strobeSeen; // strobe level last cycle
    logic [WORD_W-1:0]    addrWord, next_addrWord;    // latched address word
    logic [CNT_W-1:0]     wordCount, next_wordCount;  // index of next data word
    logic [WORD_W-1:0]    held [COEF_WORDS];          // words of the open group
    logic [WORD_W-1:0]    next_held [COEF_WORDS];
    logic [WORD_W-1:0]    grp [COEF_WORDS];           // group including this word
    logic                 next_coefWrite, next_regWrite;
    logic [COEF_ROW_W-1:0] next_coefRow;
    logic [COEF_SET_W-1:0] next_coefSet;
    logic [CLASS_W-1:0]   next_regClass, cls;
    logic [INNER_W-1:0]   next_regAddr;
    logic [REG_W-1:0]     next_regData;

    assign cls = addrWord[CLASS_LSB +: CLASS_W];

    // ------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------
    always_comb begin
        next_state      = state;
        next_strobeSeen = strobe_n;
        next_addrWord   = addrWord;
        next_wordCount  = wordCount;
        next_held       = held;
        grp             = held;
        grp[wordCount]  = loadWord;
        next_coefWrite  = 1'b0;
        next_regWrite   = 1'b0;
        next_coefRow    = coefRow;
        next_coefSet    = coefSet;
        next_regClass   = regClass;
        next_regAddr    = regAddr;
        next_regData    = regData;
        if (strobe_n) begin
            // a high strobe abandons any partial group
            next_state     = ST_IDLE; // R16
            next_wordCount = '0;      // R16
        end else begin
            case (state)
                ST_IDLE, ST_ADDR: begin
                    // only a falling strobe opens from idle
                    if (state == ST_ADDR || strobeSeen) begin
                        next_addrWord  = loadWord; // R13
                        next_wordCount = '0;
                        next_state     = ST_DATA;
                    end
                end
                ST_DATA: begin
                    next_held[wordCount] = loadWord; // R1
                    if (wordCount == lastIndex(cls)) begin // R14
                        next_state     = ST_ADDR; // R2
                        next_wordCount = '0;
                        if (cls == CLS_COEF) begin
                            next_coefWrite = 1'b1; // R1
                            next_coefRow   = addrWord[COEF_ROW_W-1:0];
                            for (int i = 0; i < COEF_WORDS; i++) begin
                                next_coefSet[i*WORD_W +: WORD_W] = grp[i];
                            end
                        end else begin
                            next_regWrite = 1'b1; // R1
                            next_regClass = cls;
                            next_regAddr  = addrWord[INNER_W-1:0];
                            if (isRound(cls)) begin
                                // low byte first, upper nibbles of each word unused
                                next_regData = {grp[3][BYTE_W-1:0], grp[2][BYTE_W-1:0],
                                                grp[1][BYTE_W-1:0], grp[0][BYTE_W-1:0]}; // R11
                            end else if (isLimit(cls)) begin
                                next_regData = {8'h00, grp[1], grp[0]}; // R12
                            end else begin
                                next_regData = {20'h00000, grp[0]};
                            end
                        end
                    end else begin
                        next_wordCount = wordCount + 3'h1;
                    end
                end
                default: next_state = ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            strobeSeen <= 1'b1;
            addrWord   <= '0;
            wordCount  <= '0;
            for (int i = 0; i < COEF_WORDS; i++) begin
                held[i] <= '0;
            end
            coefWrite  <= 1'b0;
            coefRow    <= '0;
            coefSet    <= '0;
            regWrite   <= 1'b0;
            regClass   <= '0;
            regAddr    <= '0;
            regData    <= '0;
        end else begin
            state      <= next_state;
            strobeSeen <= next_strobeSeen;
            addrWord   <= next_addrWord;
            wordCount  <= next_wordCount;
            held       <= next_held;
            coefWrite  <= next_coefWrite;
            coefRow    <= next_coefRow;
            coefSet    <= next_coefSet;
            regWrite   <= next_regWrite;
            regClass   <= next_regClass;
            regAddr    <= next_regAddr;
            regData    <= next_regData;
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence addrTaken;
        !strobe_n && (state == ST_ADDR || (state == ST_IDLE && strobeSeen));
    endsequence

    sequence singleLoad;
        (addrTaken and (loadWord[CLASS_LSB +: CLASS_W] == CLS_CONFIG)) ##1 !strobe_n;
    endsequence

    addr_capture_a: assert property (addrTaken |=> state == ST_DATA && addrWord == $past(loadWord)) // R13
        else $error("address word not latched on strobe fall");
    strobe_clear_a: assert property (strobe_n |=> state == ST_IDLE && wordCount == 3'h0) // R16
        else $error("high strobe did not clear the port");
    single_word_a: assert property (singleLoad |=> regWrite && regData[11:0] == $past(loadWord)) // R14
        else $error("config load did not commit after one word");
    round_bytes_a: assert property (regWrite && isRound(regClass) |->
        regData[7:0] == $past(loadWord[7:0], 4) && regData[31:24] == $past(loadWord[7:0], 1)) // R11
        else $error("round register bytes out of order");
    limit_halves_a: assert property (regWrite && isLimit(regClass) |->
        regData[11:0] == $past(loadWord, 2) && regData[23:12] == $past(loadWord, 1)) // R12
        else $error("limit halves misplaced");
    coef_after_eight_a: assert property (coefWrite |->
        coefSet[11:0] == $past(loadWord, 8) && coefSet[95:84] == $past(loadWord, 1)) // R1
        else $error("coefficient set not committed after eighth word");
    next_address_a: assert property ((coefWrite || regWrite) && !strobe_n |->
        state == ST_ADDR ##1 state == ST_DATA) // R2
        else $error("word after a group not taken as address");

endmodule

// *** src/dclp_loader.sv ***
// Purpose: two independent load ports feeding coefficient banks and control registers
// Assumes: host logic on the device clock; register sink drains with valid and ready
// Notes:   coefficient commits go straight out; register commits pass a two-entry buffer
//
// Function
// [R1] commit a group only after its last word
// [R2] word after a group is a new address
// [R3] host holds strobe low while supplying words
// [R4] host keeps idle ports with strobe high
// [R5] each bank only through its own port
// [R6] registers writable through either port
// [R7] the two ports run independently
// [R8] same-cycle register writes: vertical wins
// [R9] losing horizontal port carries on unaware
// [R10] host zeroes upper nibble of round words
// [R11] round register assembled low byte first
// [R12] first limit word lower, second upper
// [R13] top three address bits pick the class
// [R14] word count per class: 8,1,4,2
// [R15] address arrives with the falling strobe
// [R16] high strobe clears any partial group

`timescale 1ns/1ps

module dclp_loader (
    input  wire logic                          clock,            // device clock, 100 MHz
    input  wire logic                          rst_n,            // async reset, active low
    // ------------------------------------------------------------------
    // load ports
    // ------------------------------------------------------------------
    input  wire logic                          horiz_load_strobe_n,
    input  wire logic [dclp_pkg::WORD_W-1:0]   horiz_load_word,
    input  wire logic                          vert_load_strobe_n,
    input  wire logic [dclp_pkg::WORD_W-1:0]   vert_load_word,
    // ------------------------------------------------------------------
    // coefficient bank writes
    // ------------------------------------------------------------------
    output logic                               horizCoefWrite,
    output logic [dclp_pkg::COEF_ROW_W-1:0]    horizCoefRow,
    output logic [dclp_pkg::COEF_SET_W-1:0]    horizCoefSet,
    output logic                               vertCoefWrite,
    output logic [dclp_pkg::COEF_ROW_W-1:0]    vertCoefRow,
    output logic [dclp_pkg::COEF_SET_W-1:0]    vertCoefSet,
    // ------------------------------------------------------------------
    // control register write stream
    // ------------------------------------------------------------------
    output logic                               regValid,
    input  wire logic                          regReady,
    output logic [dclp_pkg::CLASS_W-1:0]       regClass,
    output logic [dclp_pkg::INNER_W-1:0]       regAddr,
    output logic [dclp_pkg::REG_W-1:0]         regData,
    output logic                               regAccept         // room for one more commit
);
    import dclp_pkg::*;

    // ------------------------------------------------------------------
    // port instances
    // ------------------------------------------------------------------
    logic               hRegWrite, vRegWrite;     // commit pulses from each port
    logic [CLASS_W-1:0] hRegClass, vRegClass;
    logic [INNER_W-1:0] hRegAddr, vRegAddr;
    logic [REG_W-1:0]   hRegData, vRegData;

    // each port owns its own bank outputs; no cross path exists
    dclp_port horizPort ( // R5 R7
        .clock     (clock),
        .rst_n     (rst_n),
        .strobe_n  (horiz_load_strobe_n),
        .loadWord  (horiz_load_word),
        .coefWrite (horizCoefWrite),
        .coefRow   (horizCoefRow),
        .coefSet   (horizCoefSet),
        .regWrite  (hRegWrite),
        .regClass  (hRegClass),
        .regAddr   (hRegAddr),
        .regData   (hRegData)
    );

    dclp_port vertPort ( // R5 R7
        .clock     (clock),
        .rst_n     (rst_n),
        .strobe_n  (vert_load_strobe_n),
        .loadWord  (vert_load_word),
        .coefWrite (vertCoefWrite),
        .coefRow   (vertCoefRow),
        .coefSet   (vertCoefSet),
        .regWrite  (vRegWrite),
        .regClass  (vRegClass),
        .regAddr   (vRegAddr),
        .regData   (vRegData)
    );

    // ------------------------------------------------------------------
    // arbitration of register commits
    // ------------------------------------------------------------------
    logic               pushValid;                // a register commit this cycle
    logic [ENTRY_W-1:0] pushEntry;                // {class, index, data}

    // either port may write registers; vertical takes a tie, and the
    // horizontal port is never told, so it simply moves on
    assign pushValid = hRegWrite || vRegWrite; // R6
    assign pushEntry = vRegWrite ? {vRegClass, vRegAddr, vRegData}  // R8
                                 : {hRegClass, hRegAddr, hRegData}; // R9

    // ------------------------------------------------------------------
    // two-entry buffer: output stage plus one skid entry
    // ------------------------------------------------------------------
    logic               outValid, next_outValid;   // output stage holds an entry
    logic [ENTRY_W-1:0] outEntry, next_outEntry;   // output stage contents
    logic               skidValid, next_skidValid; // skid stage holds an entry
    logic [ENTRY_W-1:0] skidEntry, next_skidEntry; // skid stage contents
    logic               next_regAccept;

    // the output stage drives the ports directly, so a stalled sink sees
    // steady data; the skid catches one commit that arrives during a stall
    always_comb begin
        next_outValid  = outValid;
        next_outEntry  = outEntry;
        next_skidValid = skidValid;
        next_skidEntry = skidEntry;
        if (outValid && regReady) begin
            // sink took the head: promote the skid or go empty
            if (skidValid) begin
                next_outEntry  = skidEntry;
                next_skidValid = 1'b0;
            end else begin
                next_outValid = 1'b0;
            end
        end
        if (pushValid) begin
            if (!next_outValid) begin
                next_outValid = 1'b1;
                next_outEntry = pushEntry;
            end else if (!next_skidValid) begin
                next_skidValid = 1'b1;
                next_skidEntry = pushEntry;
            end else begin
                // both full: the host ignored regAccept, the commit is lost
                next_skidEntry = skidEntry;
            end
        end
        // registered room flag; host waits for it before a register group
        next_regAccept = !next_skidValid;
    end

    // buffer registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            outValid  <= 1'b0;
            outEntry  <= '0;
            skidValid <= 1'b0;
            skidEntry <= '0;
            regAccept <= 1'b1;
        end else begin
            outValid  <= next_outValid;
            outEntry  <= next_outEntry;
            skidValid <= next_skidValid;
            skidEntry <= next_skidEntry;
            regAccept <= next_regAccept;
        end
    end

    // register stream outputs are slices of the output stage flops
    assign regValid = outValid;
    assign regClass = outEntry[ENTRY_W-1 -: CLASS_W];
    assign regAddr  = outEntry[REG_W +: INNER_W];
    assign regData  = outEntry[REG_W-1:0];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // on a tie the vertical entry is the one that reaches the head
    vert_priority_a: assert property (hRegWrite && vRegWrite && !outValid |=> // R8
        regValid && regData == $past(vRegData) && regClass == $past(vRegClass))
        else $error("vertical register write lost the tie");

    // a stalled sink must keep seeing the same entry
    stall_hold_a: assert property (regValid && !regReady |=> regValid && $stable(outEntry)) // R6
        else $error("register entry changed while stalled");

    // a lone horizontal commit is forwarded like a vertical one
    horiz_lone_a: assert property (hRegWrite && !vRegWrite && !outValid |=> // R6
        regValid && regAddr == $past(hRegAddr))
        else $error("horizontal register write not forwarded");

    // the losing horizontal entry must not sneak into the skid stage
    horiz_drop_a: assert property (hRegWrite && vRegWrite && !outValid |=> !skidValid) // R8
        else $error("discarded horizontal register write was buffered");

    // a pop with the skid full moves the skid entry to the head
    skid_promote_a: assert property (regValid && regReady && skidValid |=> // R6
        regValid && outEntry == $past(skidEntry))
        else $error("skid entry not promoted after a pop");

    // a pop of the only entry with nothing arriving empties the buffer
    drain_empty_a: assert property (regValid && regReady && !skidValid && !pushValid |=> // R6
        !regValid)
        else $error("buffer still valid after its last entry was taken");

endmodule

// *** sim/dclp_host_model.sv ***
// Purpose: host logic driving one load port, one queued entry per clock
// Assumes: entries are {strobe_n, word}; an empty queue means the port is idle
// Notes:   an idle port keeps its strobe high and toggles the word lines

`timescale 1ns/1ps

module dclp_host_model (
    input  wire logic                        clock,     // device clock
    output logic                             strobe_n,  // load strobe, active low
    output logic [dclp_pkg::WORD_W-1:0]      word       // address or data word
);
    import dclp_pkg::*;

    logic [WORD_W:0] pending[$];  // words still to be played out

    initial begin
        strobe_n = 1'b1;  // high from power up, so the first low is a fall
        word     = 12'h000;
    end

    // queue one cycle of port activity
    task automatic put(input logic [WORD_W:0] e);
        pending.push_back(e);
    endtask

    // ------------------------------------------------------------------
    // play out one entry per clock, change only just after the edge
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        if (pending.size() != 0) begin
            {strobe_n, word} <= pending.pop_front();
        end else begin
            strobe_n <= 1'b1;
            word     <= ~word;  // no stale value once released
        end
    end
endmodule

// *** sim/dclp_loader_tb.sv ***
// Purpose: self-checking bench for the dual load port loader
// Assumes: two host models feed the ports; the register sink is driven here
// Notes:   expected results are queued at send time and compared as they appear

`timescale 1ns/1ps

module dclp_loader_tb;
    import dclp_pkg::*;

    logic              clock = 1'b0;      // 100 MHz
    logic              rst_n = 1'b0;      // async reset, active low
    logic              regReady = 1'b0;   // sink ready
    logic              hold = 1'b1;       // sink stalls while set
    logic              hStrobe_n, vStrobe_n;
    logic [11:0]       hWord, vWord;
    logic              hWr, vWr, regValid, regAccept;
    logic [7:0]        hRow, vRow;
    logic [95:0]       hSet, vSet, s;
    logic [2:0]        regClass;
    logic [8:0]        regAddr;
    logic [31:0]       regData;
    logic [31:0]       seed = 32'h0000f746;  // 63302
    logic [103:0]      hExp[$], vExp[$];     // {row, set} per coefficient commit
    logic [43:0]       rExp[$];              // {class, addr, data} per register entry
    int                miscompares = 0;
    int                checkCount = 0;

    always #5 clock = ~clock;

    dclp_host_model u_hostH (.clock(clock), .strobe_n(hStrobe_n), .word(hWord));
    dclp_host_model u_hostV (.clock(clock), .strobe_n(vStrobe_n), .word(vWord));

    dclp_loader u_dclp_loader (
        .clock(clock), .rst_n(rst_n),
        .horiz_load_strobe_n(hStrobe_n), .horiz_load_word(hWord),
        .vert_load_strobe_n(vStrobe_n), .vert_load_word(vWord),
        .horizCoefWrite(hWr), .horizCoefRow(hRow), .horizCoefSet(hSet),
        .vertCoefWrite(vWr), .vertCoefRow(vRow), .vertCoefSet(vSet),
        .regValid(regValid), .regReady(regReady), .regClass(regClass),
        .regAddr(regAddr), .regData(regData), .regAccept(regAccept)
    );

    // xorshift source; a stall chance keeps the sink honest
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    always @(posedge clock) regReady <= !hold && (xs() % 4 != 0);

    task automatic chk(input string n, input logic [103:0] e, input logic [103:0] g);
        checkCount++;
        if (e !== g) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic completeRun();
        $display("checks %0d miscompares %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic push(input bit v, input logic [12:0] e);
        if (v) u_hostV.put(e);
        else u_hostH.put(e);
    endtask

    // address then eight coefficients, bank 0 first
    task automatic coef(input bit v, input logic [11:0] a, input logic [95:0] c);
        push(v, {1'b0, a});
        for (int i = 0; i < 8; i++) push(v, {1'b0, c[12*i +: 12]});
        if (v) vExp.push_back({a[7:0], c});
        else hExp.push_back({a[7:0], c});
    endtask

    // address then n data words; keep clear when the write must be lost
    task automatic regs(input bit v, input logic [11:0] a, input int n,
                        input logic [47:0] w, input logic [31:0] d, input bit keep);
        push(v, {1'b0, a});
        for (int i = 0; i < n; i++) push(v, {1'b0, w[12*i +: 12]});
        if (keep) rExp.push_back({a[11:9], a[8:0], d});
    endtask

    // bounded wait until everything sent has been seen
    task automatic drain(input string t);
        int k;
        k = 0;
        while (u_hostH.pending.size() + u_hostV.pending.size() + hExp.size()
               + vExp.size() + rExp.size() != 0 && k < 300) begin
            @(posedge clock);
            k++;
        end
        if (k == 300) begin
            miscompares++;
            completeRun();
        end else $display("test %s done", t);
    endtask

    // ------------------------------------------------------------------
    // result watcher: an unexpected commit meets an empty queue and fails
    // ------------------------------------------------------------------
    always @(posedge clock) if (rst_n) begin
        if (hWr !== 1'b0) chk("horizCoef", hExp.size() ? hExp.pop_front() : 'x, {hRow, hSet});
        if (vWr !== 1'b0) chk("vertCoef", vExp.size() ? vExp.pop_front() : 'x, {vRow, vSet});
        if (regValid !== 1'b0 && regReady === 1'b1)
            chk("regEntry", rExp.size() ? rExp.pop_front() : 'x, {regClass, regAddr, regData});
    end

    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        hold  <= 1'b0;
        s = {xs(), xs(), xs()};
        coef(0, 12'h00a, 96'h143_f20_832_701_9e3_c76_543_210);
        coef(1, {4'h1, s[7:0]}, s);
        coef(0, {4'h1, s[15:8]}, ~s);
        drain("coef");
        regs(0, 12'h204, 1, 48'h003, 32'h00000003, 1);
        regs(0, 12'h80c, 4, 48'h076_083_0f4_0a2, 32'h7683f4a2, 1);
        drain("horiz regs");
        regs(1, 12'he07, 2, 48'h743_390, 32'h00743390, 1);
        regs(1, 12'h402, 1, 48'h00f, 32'h0000000f, 1);
        drain("vert regs");
        regs(0, 12'h205, 1, 48'h0ab, 32'h0, 0);
        regs(1, 12'h203, 1, 48'h055, 32'h00000055, 1);
        regs(0, 12'h403, 1, 48'h011, 32'h00000011, 1);
        drain("priority");
        for (int i = 0; i < 4; i++) push(0, {1'b0, 12'h00a ^ i[11:0]});
        push(0, 13'h1000);
        regs(0, 12'h201, 1, 48'h07e, 32'h0000007e, 1);
        drain("abort");
        hold <= 1'b1;
        regs(0, 12'h206, 1, 48'h001, 32'h00000001, 1);
        regs(0, 12'h207, 1, 48'h002, 32'h00000002, 1);
        repeat (10) @(posedge clock);
        chk("regAccept", 104'h0, {103'h0, regAccept});
        hold <= 1'b0;
        drain("stall");
        chk("regAccept", 104'h1, {103'h0, regAccept});
        completeRun();
    end
endmodule
